// file: design/extended_register_ops.sv
// extended register operation datapath with its register bank
`timescale 1ns/100ps
module extended_register_ops
    import ext_ops_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // instruction issue
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [15:0] issue_word,
    // completion
    output logic done,
    output logic illegal,
    // architectural state
    output status_t status,
    output logic [15:0] instruction_register,
    output logic [15:0] pc,
    output logic [15:0] eff_addr,
    // register observation
    input wire logic [2:0] peek_sel,
    output logic [15:0] peek_data
);
    // ======================================================================
    // decode helpers
    function automatic logic is_ext(input logic [15:0] w, input logic [15:0] code);
        return (w & EXT_MASK) == code;
    endfunction

    function automatic logic is_rop(input logic [15:0] w);
        return w[15:11] == ROP_TOP;
    endfunction

    // pc_as_source yields the incremented counter, code zero yields zero
    function automatic logic [15:0] operand(input logic [2:0] code, input logic [15:0] data,
                                            input logic [15:0] pcv);
        if (code == REG_NONE) begin
            return 16'h0000;
        end else if (code == REG_P) begin
            return pcv;
        end else begin
            return data;
        end
    endfunction

    // ======================================================================
    // state
    state_t state;
    state_t next_state;
    logic [15:0] next_ir;
    logic [15:0] next_pc;
    logic [15:0] base;
    logic [15:0] next_base;
    logic [15:0] next_eff;
    status_t next_status;
    logic next_done;
    logic next_illegal;
    wr_port_t w0;
    wr_port_t w1;
    wr_port_t bank_w0;
    wr_port_t bank_w1;
    logic [3:0][2:0] rd_addr;
    logic [3:0][15:0] rd_data;

    // ======================================================================
    // operand fetch
    logic [2:0] src_code;
    logic [2:0] dst_code;
    logic [15:0] cur_ir;
    logic is_div;

    // in idle the word being issued steers the bank, later the held word
    assign cur_ir = (state == S_IDLE) ? issue_word : instruction_register;
    assign is_div = is_ext(instruction_register, OP_DIV);
    assign src_code = instruction_register[SR_LSB +: 3];
    assign dst_code = instruction_register[DR_LSB +: 3];

    // port 0 accumulator A, port 1 D or dr, port 2 sr, port 3 observation
    always_comb begin
        rd_addr[0] = REG_A;
        rd_addr[1] = is_ext(cur_ir, OP_DIV) ? REG_D : cur_ir[DR_LSB +: 3];
        rd_addr[2] = cur_ir[SR_LSB +: 3];
        rd_addr[3] = peek_sel;
    end

    reg_bank #(
        .RD_PORTS(4)
    ) u_bank (
        .clk(clk),
        .reset_n(reset_n),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr0(bank_w0),
        .wr1(bank_w1)
    );

    assign peek_data = (peek_sel == REG_P) ? pc : rd_data[3];

    // ======================================================================
    // arithmetic
    logic [15:0] sv;
    logic [15:0] dv;
    logic [15:0] a_val;
    logic [15:0] d_val;
    logic signed [31:0] prod;
    logic signed [31:0] dividend;
    logic signed [31:0] divisor;
    logic signed [31:0] quot;
    logic signed [31:0] rem;
    logic div_ovf;
    logic [15:0] s_op;
    logic [15:0] d_op;
    logic cin;
    logic [16:0] sum;
    logic add_ovf;
    logic [15:0] index_times_three;
    logic [15:0] disp;

    assign sv = operand(src_code, rd_data[2], pc);
    assign dv = operand(dst_code, rd_data[1], pc);
    assign a_val = rd_data[0];
    assign d_val = rd_data[1];
    // signed 16 by 16 product in one cycle
    assign prod = $signed({{16{sv[15]}}, sv}) * $signed({{16{dv[15]}}, dv});
    // divide truncates toward zero so the remainder follows the dividend
    assign dividend = $signed({a_val, d_val});
    assign divisor = (sv == 16'h0000) ? 32'sd1 : $signed({{16{sv[15]}}, sv});
    assign quot = dividend / divisor;
    assign rem = dividend % divisor;
    // quotient must fit one word, zero divisor counts as overflow
    assign div_ovf = (sv == 16'h0000) || (quot[31:15] != {17{quot[15]}});
    // register add operands
    assign s_op = instruction_register[CM1_BIT] ? ~sv : sv;
    assign d_op = instruction_register[CLD_BIT] ? 16'h0000 : dv;
    assign cin = instruction_register[I_BIT] | (instruction_register[C_BIT] & status.c);
    assign sum = {1'b0, d_op} + {1'b0, s_op} + {16'h0000, cin};
    assign add_ovf = (d_op[15] == s_op[15]) && (sum[15] != d_op[15]);
    assign index_times_three = 16'((a_val - 16'h0001) * 16'h0003);
    assign disp = {{(16 - DISP_W){instruction_register[DISP_W-1]}},
                   instruction_register[DISP_W-1:0]};

    // program counter writes go to the counter, not the bank
    always_comb begin
        bank_w0 = w0;
        bank_w1 = w1;
        bank_w0.en = w0.en && (w0.addr != REG_P);
        bank_w1.en = w1.en && (w1.addr != REG_P);
    end

    // ======================================================================
    // sequencer and execution
    always_comb begin
        next_state = state;
        next_ir = instruction_register;
        next_pc = pc;
        next_base = base;
        next_eff = eff_addr;
        next_status = status;
        next_done = 1'b0;
        next_illegal = 1'b0;
        w0 = '0;
        w1 = '0;
        case (state)
            S_IDLE: begin
                if (issue_valid) begin
                    next_ir = issue_word;
                    next_base = pc;
                    next_pc = 16'(pc + 16'h0001);
                    next_state = S_ADDR;
                end
            end
            S_ADDR: begin
                next_state = S_EXEC;
            end
            S_EXEC: begin
                next_state = S_IDLE;
                next_done = 1'b1;
                // relative addressing counts from the issuing instruction
                next_eff = 16'(base + disp);
                if (is_ext(instruction_register, OP_EXR)) begin
                    if (is_ext(sv, OP_EXR)) begin
                        next_status.z = 1'b1;
                        next_illegal = 1'b1;
                    end else begin
                        next_ir = sv;
                        next_state = S_ADDR;
                        next_done = 1'b0;
                    end
                end else if (is_ext(instruction_register, OP_MPY)) begin
                    w0 = '{en: 1'b1, addr: REG_A, data: prod[31:16]};
                    w1 = '{en: 1'b1, addr: REG_D, data: prod[15:0]};
                end else if (is_div) begin
                    // overflow leaves A and D alone
                    if (!div_ovf) begin
                        w0 = '{en: 1'b1, addr: REG_A, data: quot[15:0]};
                        w1 = '{en: 1'b1, addr: REG_D, data: rem[15:0]};
                    end
                    next_status.z = div_ovf;
                    next_status.q = div_ovf;
                    next_status.o = status.o | div_ovf;
                    next_status.c = 1'b0;
                end else if (is_ext(instruction_register, OP_INDEX_TIMES_THREE)) begin
                    w0 = '{en: 1'b1, addr: REG_X, data: index_times_three};
                end else if (instruction_register[15:11] == JPL_TOP) begin
                    // pc already points past the jump or its executing word
                    w0 = '{en: 1'b1, addr: REG_L, data: pc};
                    next_pc = 16'(base + disp);
                end else if (is_rop(instruction_register)) begin
                    if (instruction_register[RAD_BIT]) begin
                        w0 = '{en: 1'b1, addr: dst_code, data: sum[15:0]};
                        next_status.c = sum[16];
                        next_status.q = add_ovf;
                        next_status.o = status.o | add_ovf;
                    end else begin
                        case (instruction_register[C_BIT:I_BIT])
                            2'b00: begin
                                // swap, zero destination clears the source
                                w0 = '{en: 1'b1, addr: dst_code, data: s_op};
                                w1 = '{en: 1'b1, addr: src_code, data: d_op};
                            end
                            2'b01: w0 = '{en: 1'b1, addr: dst_code, data: d_op & s_op};
                            2'b10: w0 = '{en: 1'b1, addr: dst_code, data: d_op ^ s_op};
                            default: w0 = '{en: 1'b1, addr: dst_code, data: d_op | s_op};
                        endcase
                    end
                end
                if (w0.en && w0.addr == REG_P) begin
                    next_pc = w0.data;
                end else if (w1.en && w1.addr == REG_P) begin
                    next_pc = w1.data;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_IDLE;
            instruction_register <= IR_RESET;
            pc <= PC_RESET;
            base <= PC_RESET;
            eff_addr <= PC_RESET;
            status <= STATUS_RESET;
            done <= 1'b0;
            illegal <= 1'b0;
        end else begin
            state <= next_state;
            instruction_register <= next_ir;
            pc <= next_pc;
            base <= next_base;
            eff_addr <= next_eff;
            status <= next_status;
            done <= next_done;
            illegal <= next_illegal;
        end
    end

    assign issue_ready = (state == S_IDLE);

    // ======================================================================
    // checks
    logic exec_mpy;
    logic exec_div;
    logic exec_exr;
    logic exec_swap0;
    assign exec_mpy = (state == S_EXEC) && is_ext(instruction_register, OP_MPY);
    assign exec_div = (state == S_EXEC) && is_div;
    assign exec_exr = (state == S_EXEC) && is_ext(instruction_register, OP_EXR);
    assign exec_swap0 = (state == S_EXEC) && is_rop(instruction_register) &&
        !instruction_register[RAD_BIT] && instruction_register[C_BIT:I_BIT] == 2'b00 &&
        instruction_register[CLD_BIT];

    mpy_product_a: assert property (@(posedge clk) disable iff (!reset_n)
        exec_mpy |-> w0.addr == REG_A && w1.addr == REG_D &&
            $signed({w0.data, w1.data}) == $signed(sv) * $signed(dv))
        else $error("multiply result not placed in A and D");

    mpy_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        (issue_valid && issue_ready && is_ext(issue_word, OP_MPY)) |-> ##[1:8] done)
        else $error("multiply did not finish in time");

    div_sign_a: assert property (@(posedge clk) disable iff (!reset_n)
        (exec_div && !div_ovf && w1.data != 16'h0000) |-> w1.data[15] == a_val[15])
        else $error("remainder sign differs from dividend");

    div_error_a: assert property (@(posedge clk) disable iff (!reset_n)
        exec_div |=> status.z == $past(div_ovf) && done)
        else $error("divide error flag wrong");

    div_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (exec_div && div_ovf) |-> !bank_w0.en && !bank_w1.en)
        else $error("overflowing divide changed A or D");

    div_exact_a: assert property (@(posedge clk) disable iff (!reset_n)
        (exec_div && !div_ovf) |->
            $signed(w0.data) * $signed(sv) + $signed(w1.data) == $signed({a_val, d_val}))
        else $error("quotient and remainder do not rebuild dividend");

    exr_nest_a: assert property (@(posedge clk) disable iff (!reset_n)
        (exec_exr && is_ext(sv, OP_EXR)) |=> illegal && status.z && state == S_IDLE)
        else $error("nested execute not flagged");

    exr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (exec_exr && !is_ext(sv, OP_EXR)) |=>
            instruction_register == $past(sv) && state == S_ADDR ##1 state == S_EXEC)
        else $error("executed word not loaded");

    index_times_three_only_x_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((state == S_EXEC) && is_ext(instruction_register, OP_INDEX_TIMES_THREE)) |->
            w0.addr == REG_X && !w1.en && 16'(w0.data + 16'h0003) == 16'(a_val * 16'h0003))
        else $error("index times three wrong");

    link_value_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((state == S_EXEC) && instruction_register[15:11] == JPL_TOP) |->
            w0.addr == REG_L && w0.data == 16'(base + 16'h0001))
        else $error("link value wrong");

    pc_source_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((state == S_EXEC) && src_code == REG_P) |-> sv == 16'(base + 16'h0001))
        else $error("pc source not incremented value");

    carry_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((state == S_EXEC) && is_rop(instruction_register) && instruction_register[RAD_BIT])
            |=> status.c == $past(sum[16]))
        else $error("register add carry wrong");

    swap_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        exec_swap0 |-> w0.addr == dst_code && w1.addr == src_code && w1.data == 16'h0000 &&
            w0.data == (instruction_register[CM1_BIT] ? ~sv : sv))
        else $error("swap with zero destination wrong");

    rel_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_EXEC) |=> eff_addr == 16'($past(pc) + $past(disp) - 16'h0001))
        else $error("relative address not from issuing word");

    mpy_done_c: cover property (@(posedge clk) disable iff (!reset_n) exec_mpy ##1 done);
    div_ovf_c: cover property (@(posedge clk) disable iff (!reset_n) exec_div && div_ovf);
    exr_run_c: cover property (@(posedge clk) disable iff (!reset_n)
        exec_exr ##1 state == S_ADDR ##1 state == S_EXEC ##1 done);
    exr_bad_c: cover property (@(posedge clk) disable iff (!reset_n) illegal);
    swap_zero_c: cover property (@(posedge clk) disable iff (!reset_n) exec_swap0);
endmodule // extended_register_ops

// file: common/ext_ops_pkg.sv
// constants, types and state codes shared by the extended register datapath
// ==========================================================================
package ext_ops_pkg;
    // ======================================================================
    // widths and register codes
    localparam int WORD_W = 16;
    localparam int REG_N = 8;
    localparam logic [2:0] REG_NONE = 3'h0;
    localparam logic [2:0] REG_D = 3'h1;
    localparam logic [2:0] REG_P = 3'h2;
    localparam logic [2:0] REG_L = 3'h4;
    localparam logic [2:0] REG_A = 3'h5;
    localparam logic [2:0] REG_X = 3'h7;
    // ======================================================================
    // opcodes and field positions
    localparam logic [15:0] EXT_MASK = 16'hFFC0;
    localparam logic [15:0] OP_MPY = 16'hC280;
    localparam logic [15:0] OP_DIV = 16'hC380;
    localparam logic [15:0] OP_EXR = 16'hC180;
    localparam logic [15:0] OP_INDEX_TIMES_THREE = 16'hC680;
    localparam logic [4:0] ROP_TOP = 5'h19;
    localparam logic [4:0] JPL_TOP = 5'h17;
    localparam int SR_LSB = 3;
    localparam int DR_LSB = 0;
    localparam int CLD_BIT = 6;
    localparam int CM1_BIT = 7;
    localparam int I_BIT = 8;
    localparam int C_BIT = 9;
    localparam int RAD_BIT = 10;
    localparam int DISP_W = 8;
    // ======================================================================
    // reset values and timing
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] IR_RESET = 16'h0000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MPY_TIME_NS = 7900;
    localparam int MPY_MAX_CYCLES = MPY_TIME_NS / CLK_PERIOD_NS;
    // ======================================================================
    // carriers and states
    typedef struct packed {
        logic z;
        logic c;
        logic o;
        logic q;
    } status_t;
    typedef struct packed {
        logic en;
        logic [2:0] addr;
        logic [15:0] data;
    } wr_port_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ADDR = 2'b01,
        S_EXEC = 2'b10
    } state_t;
    localparam status_t STATUS_RESET = 4'h0;
endpackage

// file: design/reg_bank.sv
// general register bank with registered read ports and two write ports
`timescale 1ns/100ps
module reg_bank
    import ext_ops_pkg::*;
#(
    parameter int RD_PORTS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // read ports
    input wire logic [RD_PORTS-1:0][2:0] rd_addr,
    output logic [RD_PORTS-1:0][WORD_W-1:0] rd_data,
    // write ports, port 0 wins on collision
    input wire wr_port_t wr0,
    input wire wr_port_t wr1
);
    // ======================================================================
    // storage
    logic [REG_N-1:0][WORD_W-1:0] mem;
    logic [REG_N-1:0][WORD_W-1:0] next_mem;
    logic [RD_PORTS-1:0][WORD_W-1:0] next_rd;

    genvar i;
    // code zero is no register and always reads zero
    generate
        for (i = 0; i < REG_N; i++) begin : g_ent
            always_comb begin
                next_mem[i] = mem[i];
                if (i != 0 && wr1.en && wr1.addr == 3'(i)) begin
                    next_mem[i] = wr1.data;
                end
                if (i != 0 && wr0.en && wr0.addr == 3'(i)) begin
                    next_mem[i] = wr0.data;
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem[i] <= 16'h0000;
                end else begin
                    mem[i] <= next_mem[i];
                end
            end
        end
        // registered read data
        for (i = 0; i < RD_PORTS; i++) begin : g_rd
            always_comb begin
                next_rd[i] = mem[rd_addr[i]];
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    rd_data[i] <= 16'h0000;
                end else begin
                    rd_data[i] <= next_rd[i];
                end
            end
        end
    endgenerate
endmodule // reg_bank

// file: test/tb_top.sv
// self-checking bench for the extended register operation datapath
`timescale 1ns/100ps
module tb_top
    import ext_ops_pkg::*;
;
    // ====================================================================
    // signals and bookkeeping
    typedef struct {int kind; logic [15:0] exp; logic [15:0] mask; string name;} note_t;
    logic clk, reset_n, issue_valid, peek_go, issue_ready, done, illegal, ov;
    logic [15:0] issue_word, pc_m, instruction_register, pc, eff_addr, peek_data;
    logic [15:0] a, b, v, base;
    logic [2:0] peek_sel;
    logic [31:0] seed, p, dvd;
    status_t status;
    longint dd, dv, qq, rr;
    int miscompares, n_tests, i;
    note_t notes[$];
    logic [15:0] mt[2] = '{16'h8000, 16'h7FFF};
    logic [31:0] dvt[6] = '{32'h00000016, 32'hFFFFFFEA, 32'h0005C654, 32'h00007FFF,
                            32'h00008000, 32'h00001234};
    logic [15:0] dst[6] = '{16'h0004, 16'h0004, 16'hFFF0, 16'h0001, 16'h0001, 16'h0000};
    // ====================================================================
    // design, clock and watchdog
    extended_register_ops u_extended_register_ops (.clk(clk), .reset_n(reset_n),
        .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_word(issue_word),
        .done(done), .illegal(illegal), .status(status),
        .instruction_register(instruction_register), .pc(pc), .eff_addr(eff_addr),
        .peek_sel(peek_sel), .peek_data(peek_data));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("[ERR] run expected finish seen timeout");
        end_of_test();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04000007 : 32'h00000000);
    endfunction
    // ====================================================================
    // monitor: oldest note against what the outputs show
    always @(posedge clk) begin
        note_t n;
        logic [15:0] seen;
        #2;
        if ((done === 1'b1 || peek_go === 1'b1) && notes.size() > 0) begin
            n = notes.pop_front();
            case (n.kind)
                0: seen = {10'h000, issue_ready, illegal, status};
                1: seen = pc;
                2: seen = instruction_register;
                3: seen = eff_addr;
                default: seen = peek_data;
            endcase
            if (n.mask != 16'h0000) begin
                n_tests++;
                if ((seen & n.mask) !== (n.exp & n.mask)) begin
                    miscompares++;
                    $display("[ERR] %s expected %h seen %h", n.name, n.exp & n.mask,
                             seen & n.mask);
                end
            end
        end
    end
    // ====================================================================
    // driver tasks
    task automatic issue(input logic [15:0] w, input int k, input logic [15:0] e,
                         input logic [15:0] m, input string nm);
        int j;
        notes.push_back(note_t'{k, e, m, nm});
        issue_word = w;
        issue_valid = 1'b1;
        @(posedge clk);
        @(negedge clk);
        issue_valid = 1'b0;
        pc_m = pc_m + 16'h0001;
        for (j = 0; j < MPY_MAX_CYCLES && done !== 1'b1; j++) @(negedge clk);
        if (done !== 1'b1) begin
            miscompares++;
            $display("[ERR] done expected 1 seen %b", done);
            end_of_test();
        end
    endtask
    task automatic chk(input logic [2:0] code, input logic [15:0] e, input string nm);
        peek_sel = code;
        @(negedge clk);
        notes.push_back(note_t'{4, e, 16'hFFFF, nm});
        peek_go = 1'b1;
        @(negedge clk);
        peek_go = 1'b0;
    endtask
    // builds a value by clear, then per bit a double and, for a one bit, an increment
    task automatic ld(input logic [2:0] code, input logic [15:0] val);
        int j;
        issue(16'hCC40 | {13'h0000, code}, 0, 16'h0000, 16'h0000, "clear");
        for (j = 15; j >= 0; j--) begin
            issue(16'hCC00 | {10'h000, code, code}, 0, 16'h0000, 16'h0000, "double");
            if (val[j]) issue(16'hCD00 | {13'h0000, code}, 0, 16'h0000, 16'h0000, "inc");
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ====================================================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        issue_valid = 1'b0;
        issue_word = 16'h0000;
        peek_sel = 3'h0;
        peek_go = 1'b0;
        seed = 32'h4A17;
        pc_m = PC_RESET;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        // signed multiply, boundary pairs then random
        for (i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            a = (i < 2) ? mt[i] : seed[15:0];
            b = (i < 2) ? 16'h8000 : seed[31:16];
            p = $signed(a) * $signed(b);
            ld(REG_X, a);
            ld(3'h6, b);
            issue(OP_MPY | 16'h003E, 0, 16'h0020, 16'h0030, "mpy_flags");
            chk(REG_A, p[31:16], "mpy_high");
            chk(REG_D, p[15:0], "mpy_low");
            chk(REG_X, a, "mpy_src_kept");
        end
        // signed divide, worked examples then random, random dest field
        for (i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            dvd = (i < 6) ? dvt[i] : {{8{seed[23]}}, seed[23:0]};
            b = (i < 6) ? dst[i] : {8'h00, seed[31:24]} - 16'h0040;
            dd = longint'($signed(dvd));
            dv = longint'($signed(b));
            ov = (dv == 0);
            if (!ov) begin
                qq = dd / dv;
                rr = dd % dv;
                ov = (qq > 32767) || (qq < -32768);
            end
            ld(REG_A, dvd[31:16]);
            ld(REG_D, dvd[15:0]);
            ld(3'h6, b);
            issue(OP_DIV | {10'h000, 3'h6, seed[2:0]}, 0, {11'h000, 1'b0, ov, 2'b00, ov},
                  16'h001D, "div_flags");
            chk(REG_A, ov ? dvd[31:16] : qq[15:0], "quotient");
            chk(REG_D, ov ? dvd[15:0] : rr[15:0], "remainder");
        end
        // index times three, including wrap at zero
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : seed[15:0];
            ld(REG_A, v);
            issue(OP_INDEX_TIMES_THREE, 0, 16'h0020, 16'h0030, "index_times_three_flags");
            chk(REG_X, (v - 16'h0001) * 16'h0003, "times_three");
            chk(REG_A, v, "index_times_three_a_kept");
        end
        // swap with zero destination operand
        ld(REG_A, 16'h5A3C);
        ld(REG_X, 16'h1111);
        issue(16'hC86F, 0, 16'h0000, 16'h0000, "swap_zero");
        chk(REG_X, 16'h5A3C, "swap_dest");
        chk(REG_A, 16'h0000, "swap_src");
        // program counter as source and direct jump and link
        base = pc_m;
        issue(16'hCC55, 1, base + 16'h0001, 16'hFFFF, "pc_copy");
        chk(REG_A, base + 16'h0001, "pc_source");
        base = pc_m;
        issue(16'hB8F0, 1, base + 16'hFFF0, 16'hFFFF, "jump_pc");
        pc_m = base + 16'hFFF0;
        chk(REG_L, base + 16'h0001, "link");
        // execute from register: plain, jump and link, nested
        ld(3'h6, OP_INDEX_TIMES_THREE);
        ld(REG_A, 16'h0010);
        issue(OP_EXR | 16'h0030, 2, OP_INDEX_TIMES_THREE, 16'hFFFF, "ir_load");
        chk(REG_X, 16'h002D, "exr_effect");
        ld(3'h6, 16'hB805);
        base = pc_m;
        issue(OP_EXR | 16'h0030, 1, base + 16'h0005, 16'hFFFF, "exr_jump");
        pc_m = base + 16'h0005;
        chk(REG_L, base + 16'h0001, "exr_link");
        ld(3'h6, 16'h0C07);
        base = pc_m;
        issue(OP_EXR | 16'h0030, 3, base + 16'h0007, 16'hFFFF, "exr_rel");
        ld(3'h6, OP_EXR | 16'h0030);
        issue(OP_EXR | 16'h0030, 0, 16'h0018, 16'h0018, "nested_exr");
        // add sets carry, add with carry chains it
        ld(REG_A, 16'hFFFF);
        ld(REG_D, 16'h0001);
        ld(REG_X, 16'h0100);
        issue(16'hCC29, 0, 16'h0004, 16'h0004, "add_carry");
        issue(16'hCE07, 0, 16'h0000, 16'h0000, "adc");
        chk(REG_X, 16'h0101, "adc_sum");
        chk(REG_D, 16'h0000, "add_sum");
        end_of_test();
    end
endmodule // tb_top
